//--- bench/apcs_pad_model.sv
// Pad model: resolves shared pin levels from block drive and board levels
`timescale 1ns/1ps

module apcs_pad_model (
    input wire apcs_pkg::apcs_port_s drive_in, // Block output values
    input wire apcs_pkg::apcs_port_s oe_n_in,  // Low where block drives
    input wire apcs_pkg::apcs_port_s board_in, // Board-side levels
    output apcs_pkg::apcs_port_s level_out     // Level seen on the pins
);
    // Output mode owns the pin; input-mode pins only see the board
    assign level_out = (drive_in & ~oe_n_in) | (board_in & oe_n_in);
endmodule : apcs_pad_model

//--- bench/test_apcs_pin_cfg.sv
// Self-checking bench of the analog pin configuration block
`timescale 1ns/1ps
`include "apcs_params.svh"

module test_apcs_pin_cfg;
    logic ref_clk_in;
    logic rst_n_in;
    apcs_pkg::apcs_bus_s bus;
    logic [7:0] rd_data;
    logic rd_valid;
    apcs_pkg::apcs_port_s level;
    apcs_pkg::apcs_port_s latch;
    apcs_pkg::apcs_port_s drive;
    apcs_pkg::apcs_port_s oe_n;
    apcs_pkg::apcs_port_s pread;
    apcs_pkg::apcs_port_s board;
    logic [3:0] dig_in_en;
    logic [11:0] analog_en;
    apcs_pkg::apcs_scan_s scan;
    apcs_pkg::apcs_func_e [12:0] func;
    int err_count;
    int checked;

    apcs_pin_cfg dut_u (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .pin_level_in(level), .port_latch_in(latch),
        .pin_drive_out(drive), .pin_oe_n_out(oe_n),
        .port_read_out(pread), .dig_in_en_out(dig_in_en),
        .analog_en_out(analog_en), .scan_cfg_out(scan),
        .pin_func_out(func)
    );

    apcs_pad_model pad_u (
        .drive_in(drive), .oe_n_in(oe_n), .board_in(board),
        .level_out(level)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic fchk(input int idx, input apcs_pkg::apcs_func_e exp);
        check($sformatf("pin_func[%0d]", idx), 16'(exp), 16'(func[idx]));
    endtask : fchk

    // Write lands next edge; derived outputs need one more
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk_in);
        bus.wr <= 1'b0;
        repeat (3) @(negedge ref_clk_in);
    endtask : wr

    task automatic rdchk(input logic [19:0] a, input logic [7:0] exp);
        @(negedge ref_clk_in);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk_in);
        bus.rd <= 1'b0;
        check("rd_valid", 16'h0001, {15'h0, rd_valid});
        check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rd_data});
    endtask : rdchk

    task automatic t_reset;
        rdchk(`APCS_ADDR_ASSIGN, 8'h10);
        rdchk(`APCS_ADDR_GATE, 8'h00);
        rdchk(`APCS_ADDR_DIR2, 8'hFF);
        rdchk(`APCS_ADDR_DIR8, 8'hFF);
        rdchk(`APCS_ADDR_DIR15, 8'hFF);
        check("oe_n", 16'hFFFF, oe_n);
        check("analog_en", 16'h0FFF, {4'h0, analog_en});
        check("dig_in_en", 16'h0000, {12'h000, dig_in_en});
        $display("test reset done");
    endtask : t_reset

    task automatic t_fixed;
        wr(`APCS_ADDR_ASSIGN, 8'hFF);
        rdchk(`APCS_ADDR_ASSIGN, 8'h1F);
        wr(`APCS_ADDR_ASSIGN, 8'h00);
        wr(`APCS_ADDR_GATE, 8'hFF);
        rdchk(`APCS_ADDR_GATE, 8'h0F);
        wr(`APCS_ADDR_DIR8, 8'h00);
        rdchk(`APCS_ADDR_DIR8, 8'hF0);
        wr(`APCS_ADDR_DIR15, 8'h00);
        rdchk(`APCS_ADDR_DIR15, 8'hF0);
        wr(`APCS_ADDR_MODE, 8'hFF);
        rdchk(`APCS_ADDR_MODE, 8'h40);
        wr(20'hF0000, 8'h55);
        rdchk(20'hF0000, 8'h00);
        wr(`APCS_ADDR_DIR8, 8'hFF);
        wr(`APCS_ADDR_DIR15, 8'hFF);
        $display("test fixed bits done");
    endtask : t_fixed

    task automatic t_assign;
        logic [11:0] exp;
        for (int v = 0; v <= 16; v++) begin
            wr(`APCS_ADDR_ASSIGN, 8'(v));
            for (int i = 0; i < 12; i++) begin
                exp[i] = (i + v >= 12);
            end
            check("analog_en", {4'h0, exp}, {4'h0, analog_en});
        end
        $display("test assign sweep done");
    endtask : t_assign

    task automatic t_scan;
        logic amp_slot;
        wr(`APCS_ADDR_ASSIGN, 8'h10);
        wr(`APCS_ADDR_GATE, 8'h00);
        wr(`APCS_ADDR_MODE, 8'h40);
        for (int a = 0; a < 2; a++) begin
            for (int n = 0; n < 8; n++) begin
                wr(`APCS_ADDR_SEL, {1'b0, 1'(a), 2'b00, 4'(n)});
                check("scan", 16'h0001, {15'h0, scan.scan});
                check("prohibited", 16'h0, {15'h0, scan.prohibited});
                for (int k = 0; k < 4; k++) begin
                    amp_slot = (a == 1) && (k == 0);
                    check("slot_amp", {15'h0, amp_slot},
                        {15'h0, scan.slot[k].amp});
                    if (!amp_slot) begin
                        check("slot_chan", 16'(n + k - a),
                            {12'h0, scan.slot[k].chan});
                    end
                end
                fchk(n + 3 - a, apcs_pkg::FUNC_ANA_CONV);
            end
            if (a == 1) begin
                fchk(12, apcs_pkg::FUNC_ANA_CONV);
            end
        end
        wr(`APCS_ADDR_SEL, 8'h08);
        check("prohibited", 16'h0001, {15'h0, scan.prohibited});
        $display("test scan table done");
    endtask : t_scan

    task automatic t_select;
        wr(`APCS_ADDR_MODE, 8'h00);
        wr(`APCS_ADDR_SEL, 8'h05);
        check("scan", 16'h0000, {15'h0, scan.scan});
        check("slot0", 16'h0005, {12'h0, scan.slot[0].chan});
        fchk(5, apcs_pkg::FUNC_ANA_CONV);
        fchk(6, apcs_pkg::FUNC_ANA_IDLE);
        $display("test select mode done");
    endtask : t_select

    task automatic t_pins;
        latch <= 16'hFFFF;
        board <= 16'hFFFF;
        wr(`APCS_ADDR_ASSIGN, 8'h08);
        wr(`APCS_ADDR_DIR2, 8'hFE);
        wr(`APCS_ADDR_GATE, 8'h0E);
        repeat (4) @(negedge ref_clk_in);
        fchk(0, apcs_pkg::FUNC_DIG_OUT);
        fchk(1, apcs_pkg::FUNC_DIG_IN);
        check("oe_n.p2", 16'h00FE, {8'h00, oe_n.p2});
        check("drive.p2", 16'h0001, {8'h00, drive.p2});
        check("read.p2", 16'h000F, {8'h00, pread.p2});
        check("read.p8", 16'h000E, {12'h000, pread.p8});
        check("read.p15", 16'h0000, {12'h000, pread.p15});
        check("dig_in_en", 16'h000E, {12'h000, dig_in_en});
        fchk(4, apcs_pkg::FUNC_ANA_IDLE);
        latch <= 16'h0000;
        repeat (4) @(negedge ref_clk_in);
        check("drive.p2", 16'h0000, {8'h00, drive.p2});
        fchk(4, apcs_pkg::FUNC_ANA_IDLE);
        wr(`APCS_ADDR_DIR2, 8'hDF);
        fchk(5, apcs_pkg::FUNC_PROHIBITED);
        $display("test pin functions done");
    endtask : t_pins

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_count++;
        summarize();
    end

    initial begin
        err_count = 0;
        checked = 0;
        rst_n_in = 1'b0;
        bus = '0;
        latch = '0;
        board = '0;
        repeat (5) @(negedge ref_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_fixed();
        t_assign();
        t_scan();
        t_select();
        t_pins();
        summarize();
    end
endmodule : test_apcs_pin_cfg

//--- design/apcs_pin_cfg.sv
// Analog pin assignment, scan channel selection and port pin functions
`timescale 1ns/1ps
`include "apcs_params.svh"
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------

module apcs_pin_cfg #(
    parameter int SYNC_STAGES = 2 // Pin level synchroniser depth
) (
    input wire logic ref_clk_in,                       // 250 MHz clock
    input wire logic rst_n_in,                         // Sync reset, low
    input wire apcs_pkg::apcs_bus_s bus_in,            // Register access
    output logic [7:0] rd_data_out,                    // Read data
    output logic rd_valid_out,                         // Read data strobe
    input wire apcs_pkg::apcs_port_s pin_level_in,     // Async pin levels
    input wire apcs_pkg::apcs_port_s port_latch_in,    // Port out latches
    output apcs_pkg::apcs_port_s pin_drive_out,        // Pin output value
    output apcs_pkg::apcs_port_s pin_oe_n_out,         // Pin drive, low on
    output apcs_pkg::apcs_port_s port_read_out,        // Port read value
    output logic [3:0] dig_in_en_out,                  // Port-8 buffers
    output logic [`APCS_NUM_CHAN-1:0] analog_en_out,   // Analog channels
    output apcs_pkg::apcs_scan_s scan_cfg_out,         // Channel list
    output apcs_pkg::apcs_func_e [`APCS_NUM_PINS-1:0] pin_func_out // Roles
);

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [7:0] assign_r, gate_r, dir2_r, dir8_r, dir15_r, mode_r, sel_r;
    logic [7:0] rd_nxt;
    apcs_pkg::apcs_port_s level_sync;
    logic [`APCS_NUM_PINS-1:0] ana, dir_in, sel;
    apcs_pkg::apcs_scan_s scan_nxt;
    apcs_pkg::apcs_func_e [`APCS_NUM_PINS-1:0] func_nxt;

    default clocking cb_chk @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    function automatic logic wr_hit(input apcs_pkg::apcs_bus_s b,
                                    input logic [`APCS_ADDR_W-1:0] a);
        return b.wr && (b.addr == a);
    endfunction : wr_hit

    // Analog when channel index plus field reaches twelve
    function automatic logic [`APCS_NUM_CHAN-1:0] analog_mask(
            input logic [4:0] field);
        logic [`APCS_NUM_CHAN-1:0] m;
        m = '0;
        for (int i = 0; i < `APCS_NUM_CHAN; i++) begin
            m[i] = (i + int'(field)) >= `APCS_NUM_CHAN;
        end
        return m;
    endfunction : analog_mask

    // -----------------------------------------------------------------
    // Register writes; fixed bits are masked off at the write, or forced to one in the port 8 and 15 direction registers
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            assign_r <= `APCS_ASSIGN_RST;
        end else if (wr_hit(bus_in, `APCS_ADDR_ASSIGN)) begin
            assign_r <= bus_in.wdata & `APCS_ASSIGN_MASK;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            gate_r <= `APCS_GATE_RST;
        end else if (wr_hit(bus_in, `APCS_ADDR_GATE)) begin
            gate_r <= bus_in.wdata & `APCS_GATE_MASK;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            dir2_r <= `APCS_DIR_RST;
            dir8_r <= `APCS_DIR_RST;
            dir15_r <= `APCS_DIR_RST;
        end else begin
            if (wr_hit(bus_in, `APCS_ADDR_DIR2)) begin
                dir2_r <= bus_in.wdata;
            end
            if (wr_hit(bus_in, `APCS_ADDR_DIR8)) begin
                dir8_r <= bus_in.wdata | `APCS_DIR_FIXED;
            end
            if (wr_hit(bus_in, `APCS_ADDR_DIR15)) begin
                dir15_r <= bus_in.wdata | `APCS_DIR_FIXED;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            mode_r <= `APCS_MODE_RST;
            sel_r <= `APCS_SEL_RST;
        end else begin
            if (wr_hit(bus_in, `APCS_ADDR_MODE)) begin
                mode_r <= bus_in.wdata & `APCS_MODE_MASK;
            end
            // Bits that must be written as zero are simply not stored
            if (wr_hit(bus_in, `APCS_ADDR_SEL)) begin
                sel_r <= bus_in.wdata & `APCS_SEL_MASK;
            end
        end
    end

    // -----------------------------------------------------------------
    // Register reads, one cycle after the strobe
    // -----------------------------------------------------------------
    always_comb begin
        if (bus_in.addr == `APCS_ADDR_ASSIGN) begin
            rd_nxt = assign_r;
        end else if (bus_in.addr == `APCS_ADDR_GATE) begin
            rd_nxt = gate_r;
        end else if (bus_in.addr == `APCS_ADDR_DIR2) begin
            rd_nxt = dir2_r;
        end else if (bus_in.addr == `APCS_ADDR_DIR8) begin
            rd_nxt = dir8_r;
        end else if (bus_in.addr == `APCS_ADDR_DIR15) begin
            rd_nxt = dir15_r;
        end else if (bus_in.addr == `APCS_ADDR_MODE) begin
            rd_nxt = mode_r;
        end else if (bus_in.addr == `APCS_ADDR_SEL) begin
            rd_nxt = sel_r;
        end else begin
            rd_nxt = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= bus_in.rd;
            rd_data_out <= bus_in.rd ? rd_nxt : 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // Pin levels come from outside the clock domain
    // -----------------------------------------------------------------
    apcs_sync #(
        .WIDTH($bits(apcs_pkg::apcs_port_s)),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(pin_level_in),
        .q_out(level_sync)
    );

    // -----------------------------------------------------------------
    // Pin role decode; pin 12 is the amplifier input
    // -----------------------------------------------------------------
    assign ana = {~gate_r[0], analog_mask(assign_r[4:0])};
    assign dir_in = {dir8_r[0], dir15_r[3:0], dir2_r};

    always_comb begin
        for (int i = 0; i < `APCS_NUM_PINS; i++) begin
            if (!ana[i]) begin
                func_nxt[i] = dir_in[i] ? apcs_pkg::FUNC_DIG_IN
                                        : apcs_pkg::FUNC_DIG_OUT;
            end else if (!dir_in[i]) begin
                func_nxt[i] = apcs_pkg::FUNC_PROHIBITED;
            end else begin
                func_nxt[i] = sel[i] ? apcs_pkg::FUNC_ANA_CONV
                                     : apcs_pkg::FUNC_ANA_IDLE;
            end
        end
    end

    // -----------------------------------------------------------------
    // Scan slot list handed to the converter core
    // -----------------------------------------------------------------
    always_comb begin
        logic scan;
        logic amp;
        int n;
        scan = mode_r[`APCS_SCAN_MODE_BIT];
        amp = sel_r[`APCS_AMP_FIRST_BIT];
        n = int'(sel_r[3:0]);
        scan_nxt.scan = scan;
        scan_nxt.prohibited = scan ? (n > `APCS_SCAN_CODE_MAX)
                                   : (!amp && n >= `APCS_NUM_CHAN);
        for (int k = 0; k < `APCS_NUM_SLOTS; k++) begin
            scan_nxt.slot[k].amp = amp && (k == 0);
            if ((amp && k == 0) || (!scan && k != 0)) begin
                scan_nxt.slot[k].chan = 4'h0;
            end else if (scan) begin
                scan_nxt.slot[k].chan = 4'(n + k - int'(amp));
            end else begin
                scan_nxt.slot[k].chan = 4'(n);
            end
        end
    end

    // Converted pins follow the slot list; a prohibited code selects none
    always_comb begin
        sel = '0;
        for (int k = 0; k < `APCS_NUM_SLOTS; k++) begin
            if (!scan_nxt.prohibited && (scan_nxt.scan || k == 0)) begin
                if (scan_nxt.slot[k].amp) begin
                    sel[`APCS_AMP_PIN] = 1'b1;
                end else begin
                    sel[scan_nxt.slot[k].chan] = 1'b1;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Registered outputs
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            scan_cfg_out <= '0;
            pin_func_out <= {`APCS_NUM_PINS{apcs_pkg::FUNC_DIG_IN}};
            analog_en_out <= '0;
            dig_in_en_out <= 4'h0;
        end else begin
            scan_cfg_out <= scan_nxt;
            pin_func_out <= func_nxt;
            analog_en_out <= ana[`APCS_NUM_CHAN-1:0];
            dig_in_en_out <= gate_r[3:0];
        end
    end

    // Latch only reaches the pin when the driver is on
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pin_oe_n_out <= '1;
            pin_drive_out <= '0;
        end else begin
            pin_oe_n_out <= {dir15_r[3:0], dir8_r[3:0], dir2_r};
            pin_drive_out <= port_latch_in
                & ~{dir15_r[3:0], dir8_r[3:0], dir2_r};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            port_read_out <= '0;
        end else begin
            port_read_out.p2 <= level_sync.p2 & ~ana[7:0];
            port_read_out.p15 <= level_sync.p15 & ~ana[11:8];
            port_read_out.p8 <= level_sync.p8 & gate_r[3:0];
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_scan_plain;
        mode_r[6] && !sel_r[6] && sel_r[3:0] <= 4'h7;
    endsequence
    property p_scan_plain;
        s_scan_plain |=> scan_cfg_out.slot[3].chan
            == $past(sel_r[3:0]) + 4'h3 && !scan_cfg_out.slot[0].amp;
    endproperty
    a_scan_plain: assert property (p_scan_plain)
        else $error("scan slot 3 channel wrong");
    property p_amp_first;
        (mode_r[6] && sel_r[6]) |=> scan_cfg_out.slot[0].amp
            && scan_cfg_out.slot[1].chan == $past(sel_r[3:0]);
    endproperty
    a_amp_first: assert property (p_amp_first)
        else $error("amplifier slot order wrong");
    property p_assign_write;
        wr_hit(bus_in, `APCS_ADDR_ASSIGN)
            |=> assign_r == {3'h0, $past(bus_in.wdata[4:0])};
    endproperty
    a_assign_write: assert property (p_assign_write)
        else $error("pin assignment write wrong");
    property p_cumulative;
        (analog_en_out[10:0] & ~analog_en_out[11:1]) == 11'h000;
    endproperty
    a_cumulative: assert property (p_cumulative)
        else $error("analog channels not contiguous from top");
    sequence s_gate_write;
        wr_hit(bus_in, `APCS_ADDR_GATE) ##1 1'b1;
    endsequence
    property p_gate;
        s_gate_write |=> dig_in_en_out == $past(bus_in.wdata[3:0], 2);
    endproperty
    a_gate: assert property (p_gate)
        else $error("input gate not applied");
    property p_drive_off;
        (pin_drive_out & pin_oe_n_out) == '0;
    endproperty
    a_drive_off: assert property (p_drive_off)
        else $error("pin driven value while buffer off");
    property p_dir_fixed;
        wr_hit(bus_in, `APCS_ADDR_DIR8) |=> ##1 pin_oe_n_out.p8
            == $past(bus_in.wdata[3:0], 2) && dir8_r[7:4] == 4'hF;
    endproperty
    a_dir_fixed: assert property (p_dir_fixed)
        else $error("port 8 direction wrong");
    property p_analog_zero;
        (port_read_out.p2 & analog_en_out[7:0]) == 8'h00
            && (port_read_out.p15 & analog_en_out[11:8]) == 4'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin read not zero");
    property p_func;
        (ana[0] && dir_in[0] && sel[0])
            |=> pin_func_out[0] == apcs_pkg::FUNC_ANA_CONV;
    endproperty
    a_func: assert property (p_func)
        else $error("converted analog role missing");
    property p_mode;
        wr_hit(bus_in, `APCS_ADDR_MODE)
            |=> ##1 scan_cfg_out.scan == $past(bus_in.wdata[6], 2);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode bit not applied");

endmodule : apcs_pin_cfg

//--- design/apcs_sync.sv
// Multi-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps

module apcs_sync #(
    parameter int WIDTH = 16, // Bits carried
    parameter int STAGES = 2  // Flip-flops in the chain
) (
    input wire logic ref_clk_in,          // Block clock
    input wire logic rst_n_in,            // Sync reset, active low
    input wire logic [WIDTH-1:0] d_in,    // Asynchronous levels
    output logic [WIDTH-1:0] q_out        // Synchronised levels
);

    logic [WIDTH-1:0] stage_r [STAGES];

    if (STAGES < 2) begin : g_bad
        $error("apcs_sync needs at least two stages");
    end

    // -----------------------------------------------------------------
    // Chain: each stage is read only by the next one
    // -----------------------------------------------------------------
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
        always_ff @(posedge ref_clk_in) begin
            if (!rst_n_in) begin
                stage_r[i] <= '0;
            end else begin
                stage_r[i] <= (i == 0) ? d_in : stage_r[(i == 0) ? 0 : i-1];
            end
        end
    end

    assign q_out = stage_r[STAGES-1];

endmodule : apcs_sync

//--- include/apcs_params.svh
// Offsets, field positions and reset values of the pin configuration block
`ifndef APCS_PARAMS_SVH
`define APCS_PARAMS_SVH

// ---------------------------------------------------------------------
// Bus and register addresses
// ---------------------------------------------------------------------
`define APCS_ADDR_W 20
`define APCS_ADDR_ASSIGN 20'hF0017
`define APCS_ADDR_GATE 20'hF0048
`define APCS_ADDR_DIR2 20'hFFF22
`define APCS_ADDR_DIR8 20'hFFF28
`define APCS_ADDR_DIR15 20'hFFF2F
`define APCS_ADDR_MODE 20'hFFF30
`define APCS_ADDR_SEL 20'hFFF31

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define APCS_ASSIGN_RST 8'h10
`define APCS_GATE_RST 8'h00
`define APCS_DIR_RST 8'hFF
`define APCS_MODE_RST 8'h00
`define APCS_SEL_RST 8'h00

// ---------------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------------
`define APCS_ASSIGN_MASK 8'h1F
`define APCS_GATE_MASK 8'h0F
`define APCS_DIR_FIXED 8'hF0
`define APCS_MODE_MASK 8'h40
`define APCS_SEL_MASK 8'h4F
`define APCS_SCAN_MODE_BIT 6
`define APCS_AMP_FIRST_BIT 6
`define APCS_NUM_CHAN 12
`define APCS_NUM_PINS 13
`define APCS_AMP_PIN 12
`define APCS_NUM_SLOTS 4
`define APCS_SCAN_CODE_MAX 7

`endif

//--- include/apcs_pkg.sv
// Types shared by the pin configuration block
`include "apcs_params.svh"

package apcs_pkg;

    // -----------------------------------------------------------------
    // Pin function and carriers
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        FUNC_DIG_IN = 3'h0,
        FUNC_DIG_OUT = 3'h1,
        FUNC_ANA_CONV = 3'h2,
        FUNC_ANA_IDLE = 3'h3,
        FUNC_PROHIBITED = 3'h4
    } apcs_func_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`APCS_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } apcs_bus_s;

    typedef struct packed {
        logic [3:0] p15;
        logic [3:0] p8;
        logic [7:0] p2;
    } apcs_port_s;

    typedef struct packed {
        logic amp;
        logic [3:0] chan;
    } apcs_slot_s;

    typedef struct packed {
        logic scan;
        logic prohibited;
        apcs_slot_s [`APCS_NUM_SLOTS-1:0] slot;
    } apcs_scan_s;

endpackage : apcs_pkg
